// file: verilog/lsf_pkg.sv
// constants and carrier types for the led sink fault detection logic
package lsf_pkg;
	// channel count and the serial word built from it
	localparam int CH = 16;
	localparam logic [15:0] WORD_RST = 16'h0000;
	// mode sequences, bit k holds the pin level sampled at clock k+1
	localparam int SEQ_LEN = 5;
	localparam logic [4:0] SEQ_BLANK = 5'h1D;
	localparam logic [4:0] ENTRY_LATCH = 5'h08;
	localparam logic [4:0] EXIT_LATCH = 5'h00;
	localparam logic [2:0] STEP_LAST = 3'h4;
	// system clock period
	localparam int SYS_PERIOD_NS = 50;
	// least time blanking stays low for one evaluation, rounded up
	localparam int EVAL_MIN_NS = 1000;
	localparam int EVAL_CYC = (EVAL_MIN_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
	// output turn-on delay after a wake from power saving, rounded up
	localparam int TURN_ON_NS = 20;
	localparam int TURN_ON_RAW = (TURN_ON_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
	localparam int TURN_ON_CYC = (TURN_ON_RAW < 1) ? 1 : TURN_ON_RAW;
	localparam logic [7:0] EVAL_LAST = 8'(EVAL_CYC - 1);
	localparam logic [3:0] TON_LOAD = 4'(TURN_ON_CYC);

	// one sample of the two dual-purpose control pins
	typedef struct packed {
		logic blank_n;
		logic latch;
	} lsf_pair_s;

	// per-channel comparator flags from the analog sense stage
	typedef struct packed {
		logic [15:0] cur_half_ok;
		logic [15:0] volt_hi;
		logic [15:0] volt_lo;
	} lsf_sense_s;
endpackage

// file: verilog/lsf_mode_seq.sv
// entry and exit sequence detector on the serial clock
`timescale 1ns/10ps
module lsf_mode_seq (
	// serial link clock and its reset
	input wire logic clk,
	input wire logic rst_n,
	// pin pair sampled at each rising edge
	input lsf_pkg::lsf_pair_s pair,
	// detection mode level
	output logic det_q
);
	logic [2:0] step_q;
	logic [4:0] exp_latch;
	logic hit;
	logic first;

	// pattern shared by both sequences except the latch level of clock 4
	always_comb begin
		exp_latch = det_q ? lsf_pkg::EXIT_LATCH : lsf_pkg::ENTRY_LATCH;
		hit = (pair.blank_n == lsf_pkg::SEQ_BLANK[step_q]) &&
			(pair.latch == exp_latch[step_q]);
		first = (pair.blank_n == lsf_pkg::SEQ_BLANK[0]) && (pair.latch == exp_latch[0]);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			step_q <= 3'h0;
		end else if (hit) begin
			step_q <= (step_q == lsf_pkg::STEP_LAST) ? 3'h0 : step_q + 3'h1;
		end else begin
			step_q <= first ? 3'h1 : 3'h0;
		end
	end

	// mode toggles on the fifth matching clock, exit accepted at any time
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			det_q <= 1'b0;
		end else if (hit && step_q == lsf_pkg::STEP_LAST) begin
			det_q <= !det_q;
		end
	end

	a_entry_detect: assert property (@(posedge clk) disable iff (!rst_n)
		(!det_q && step_q == 3'h0 && pair == 2'b10) ##1 (pair == 2'b00) ##1
		(pair == 2'b10) ##1 (pair == 2'b11) ##1 (pair == 2'b10) |=> det_q)
		else $error("entry sequence not recognised");
	a_exit_detect: assert property (@(posedge clk) disable iff (!rst_n)
		(det_q && step_q == 3'h0 && pair == 2'b10) ##1 (pair == 2'b00) ##1
		(pair == 2'b10) ##1 (pair == 2'b10) ##1 (pair == 2'b10) |=> !det_q)
		else $error("exit sequence not recognised");
	a_match_restart: assert property (@(posedge clk) disable iff (!rst_n)
		!hit |=> step_q <= 3'h1)
		else $error("detector did not restart after mismatch");
endmodule

// file: verilog/lsf_top.sv
// led sink driver core: shift chain, latch, outputs, fault detection, power saving
`timescale 1ns/10ps
module lsf_top #(
	parameter int CH = lsf_pkg::CH
) (
	// system clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// serial link from the host
	input wire logic serial_clk,
	input wire logic serial_in,
	input wire logic latch_strobe_modesel_a,
	input wire logic blank_n_modesel_b,
	output logic serial_out,
	// analog sense flags and channel drive
	input lsf_pkg::lsf_sense_s sensed_channel_current,
	output logic [CH-1:0] sink_channel,
	// status levels
	output logic power_save,
	output logic fault_mode
);
	logic rs_m_q;
	logic rst_n;
	logic lr_m_q;
	logic lrst_n;
	logic [CH-1:0] sr_q;
	logic [CH-1:0] sr_shift;
	logic [CH-1:0] lat_q;
	logic lat_tgl_q;
	logic det_link;
	logic rt_m_q;
	logic rt_s_q;
	logic rt_prev_q;
	logic bl_m_q;
	logic bl_s_q;
	logic bl_prev_q;
	logic dm_m_q;
	logic dm_s_q;
	logic lt_m_q;
	logic lt_s_q;
	logic lt_prev_q;
	lsf_pkg::lsf_sense_s se_m_q;
	lsf_pkg::lsf_sense_s se_s_q;
	logic [CH-1:0] lat_sys_q;
	logic ps_q;
	logic [3:0] ton_q;
	logic [CH-1:0] sink_q;
	logic [7:0] eval_q;
	logic eval_on;
	logic eval_done_q;
	logic [CH-1:0] short_q;
	logic [CH-1:0] res_q;
	logic res_tgl_q;
	logic fm_q;
	logic [CH-1:0] cur_ok;
	logic [CH-1:0] vhi;
	logic [CH-1:0] vlo;
	lsf_pkg::lsf_pair_s pair;

	assign pair = '{blank_n: blank_n_modesel_b, latch: latch_strobe_modesel_a};
	assign cur_ok = se_s_q.cur_half_ok;
	assign vhi = se_s_q.volt_hi;
	assign vlo = se_s_q.volt_lo;
	assign sr_shift = {sr_q[CH-2:0], serial_in};

	// system reset release through two flops
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rs_m_q <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rs_m_q <= 1'b1;
			rst_n <= rs_m_q;
		end
	end

	// link reset: the serial clock may stand still, so release waits for two edges
	always_ff @(posedge serial_clk or negedge rst_n) begin
		if (!rst_n) begin
			lr_m_q <= 1'b0;
			lrst_n <= 1'b0;
		end else begin
			lr_m_q <= 1'b1;
			lrst_n <= lr_m_q;
		end
	end

	// mode sequence detector on the link clock
	lsf_mode_seq u_seq (
		.clk(serial_clk),
		.rst_n(lrst_n),
		.pair(pair),
		.det_q(det_link)
	);

	// result toggle from the system side, two flops then edge compare
	always_ff @(posedge serial_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			rt_m_q <= 1'b0;
			rt_s_q <= 1'b0;
			rt_prev_q <= 1'b0;
		end else begin
			rt_m_q <= res_tgl_q;
			rt_s_q <= rt_m_q;
			rt_prev_q <= rt_s_q;
		end
	end

	// shifting pauses only for a result load, so data are taken on every edge of the new mode except that one
	// a result load replaces one shift; res_q is stable under the toggle
	// results land bit i on position i, so they leave msb first as data do
	always_ff @(posedge serial_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			sr_q <= lsf_pkg::WORD_RST;
		end else if (rt_s_q != rt_prev_q) begin
			sr_q <= res_q;
		end else begin
			sr_q <= sr_shift;
		end
	end

	// every link edge outside a result load shifts one bit in; reset edge excluded
	a_chain_shift: assert property (@(posedge serial_clk) disable iff (!lrst_n)
		(lrst_n && rt_s_q == rt_prev_q) |=> sr_q == $past(sr_shift))
		else $error("chain did not shift on a link edge");

	// latch transparent while high, sampled on the link clock
	always_ff @(posedge serial_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			lat_q <= lsf_pkg::WORD_RST;
			lat_tgl_q <= 1'b0;
		end else if (latch_strobe_modesel_a) begin
			lat_q <= sr_shift;
			lat_tgl_q <= !lat_tgl_q;
		end
	end

	// serial output is the msb of the chain
	assign serial_out = sr_q[CH-1];

	// two-flop synchronisers for pins and link levels
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			bl_m_q <= 1'b1;
			bl_s_q <= 1'b1;
			dm_m_q <= 1'b0;
			dm_s_q <= 1'b0;
			lt_m_q <= 1'b0;
			lt_s_q <= 1'b0;
			se_m_q <= '0;
			se_s_q <= '0;
		end else begin
			bl_m_q <= blank_n_modesel_b;
			bl_s_q <= bl_m_q;
			dm_m_q <= det_link;
			dm_s_q <= dm_m_q;
			lt_m_q <= lat_tgl_q;
			lt_s_q <= lt_m_q;
			se_m_q <= sensed_channel_current;
			se_s_q <= se_m_q;
		end
	end

	// edge history of the synchronised blank and latch toggle levels
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			bl_prev_q <= 1'b1;
			lt_prev_q <= 1'b0;
		end else begin
			bl_prev_q <= bl_s_q;
			lt_prev_q <= lt_s_q;
		end
	end

	// latch copy; a word changing during capture is retaken on the next toggle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			lat_sys_q <= lsf_pkg::WORD_RST;
		end else if (lt_s_q != lt_prev_q) begin
			lat_sys_q <= lat_q;
		end
	end

	// start asleep; sleep while the latch holds no active bit
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ps_q <= 1'b1;
		end else begin
			ps_q <= (lat_sys_q == lsf_pkg::WORD_RST);
		end
	end

	// asleep means dark outputs, and any active bit wakes the driver
	a_sleep_dark: assert property (@(posedge sys_clk) disable iff (!rst_n)
		ps_q |=> sink_q == '0)
		else $error("output lit while asleep");
	a_wake_on_data: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(lat_sys_q != '0) |=> !ps_q)
		else $error("no wake on active latch data");

	// wake arms the turn-on delay before the first output may switch
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ton_q <= 4'h0;
		end else if (ps_q && lat_sys_q != lsf_pkg::WORD_RST) begin
			ton_q <= lsf_pkg::TON_LOAD;
		end else if (ton_q != 4'h0) begin
			ton_q <= ton_q - 4'h1;
		end
	end

	// the wake delay keeps every output dark until it has run out
	a_turn_on_dark: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(ton_q != 4'h0) |=> sink_q == '0)
		else $error("output lit during turn-on delay");

	// blank high forces all off; detection mode drives the same way
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sink_q <= lsf_pkg::WORD_RST;
		end else if (!bl_s_q && !ps_q && ton_q == 4'h0) begin
			sink_q <= lat_sys_q;
		end else begin
			sink_q <= lsf_pkg::WORD_RST;
		end
	end
	assign sink_channel = sink_q;

	// evaluation window open while in detection mode with blank low
	assign eval_on = dm_s_q && !bl_s_q;

	// count the low time of blank; a short pulse gives no result
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			eval_q <= 8'h00;
		end else if (!eval_on) begin
			eval_q <= 8'h00;
		end else if (eval_q != lsf_pkg::EVAL_LAST) begin
			eval_q <= eval_q + 8'h01;
		end
	end

	// hysteresis: set at the high threshold, clear at the low one
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			short_q <= lsf_pkg::WORD_RST;
		end else if (eval_on) begin
			short_q <= vhi | (short_q & ~vlo);
		end
	end

	// capture at the end of the least window, one means fault-free
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			res_q <= lsf_pkg::WORD_RST;
			eval_done_q <= 1'b0;
		end else if (eval_on && eval_q == lsf_pkg::EVAL_LAST && !eval_done_q) begin
			res_q <= cur_ok & ~short_q;
			eval_done_q <= 1'b1;
		end else if (bl_s_q && !bl_prev_q) begin
			eval_done_q <= 1'b0;
		end
	end

	// a result is only captured inside an open detection window
	a_capture_window: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(!eval_on && !eval_done_q) |=> !eval_done_q)
		else $error("result captured outside detection window");

	// hand the results to the link side when blank returns high
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			res_tgl_q <= 1'b0;
		end else if (bl_s_q && !bl_prev_q && eval_done_q) begin
			res_tgl_q <= !res_tgl_q;
		end
	end

	// status outputs from flops
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			fm_q <= 1'b0;
		end else begin
			fm_q <= dm_s_q;
		end
	end
	assign fault_mode = fm_q;
	assign power_save = ps_q;

	a_blank_forces_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
		bl_s_q |=> sink_q == '0)
		else $error("outputs on while blank high");
	a_sleep_on_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(lat_sys_q == '0) ##1 (lat_sys_q == '0) |-> ps_q ##1 (sink_q == '0))
		else $error("no power saving with empty latch");
	a_wake_delay: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$fell(ps_q) |-> (ton_q != 4'h0) ##1 (sink_q == '0))
		else $error("output switched at once after wake");
	a_drive_follows: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(!bl_s_q && !ps_q && ton_q == 4'h0) |=> sink_q == $past(lat_sys_q))
		else $error("enabled outputs not following latch");
	a_short_hyst: assert property (@(posedge sys_clk) disable iff (!rst_n)
		eval_on |=> ((short_q & $past(vhi)) == $past(vhi)) &&
		((short_q & $past(vlo) & ~$past(vhi)) == '0))
		else $error("short flag thresholds wrong");
	a_result_value: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(eval_on && eval_q == lsf_pkg::EVAL_LAST && !eval_done_q) |=>
		eval_done_q && res_q == ($past(cur_ok) & ~$past(short_q)))
		else $error("result word not captured");
	a_result_handoff: assert property (@(posedge sys_clk) disable iff (!rst_n)
		($rose(bl_s_q) && eval_done_q) |=> res_tgl_q != $past(res_tgl_q))
		else $error("results not handed over");
	a_no_early_result: assert property (@(posedge sys_clk) disable iff (!rst_n)
		($rose(bl_s_q) && !eval_done_q) |=> $stable(res_tgl_q))
		else $error("result handed over after short window");
	a_result_load: assert property (@(posedge serial_clk) disable iff (!lrst_n)
		(rt_s_q != rt_prev_q) |=> sr_q == $past(res_q))
		else $error("results not loaded into chain");
	a_latch_follow: assert property (@(posedge serial_clk) disable iff (!lrst_n)
		latch_strobe_modesel_a |=> lat_q == sr_q)
		else $error("latch not transparent");
	a_latch_hold: assert property (@(posedge serial_clk) disable iff (!lrst_n)
		!latch_strobe_modesel_a |=> $stable(lat_q))
		else $error("latch changed while low");
endmodule

// file: tb/lsf_host_model.sv
// host side model driving the serial clock, data, latch and blank pins
`timescale 1ns/10ps
module lsf_host_model (
	// pins toward the driver
	output logic serial_clk,
	output logic serial_in,
	output logic latch_strobe_modesel_a,
	output logic blank_n_modesel_b,
	input wire logic serial_out
);
	// idle pins: clock stands low, blank high keeps the outputs dark
	initial begin
		serial_clk = 1'b0;
		serial_in = 1'b0;
		latch_strobe_modesel_a = 1'b0;
		blank_n_modesel_b = 1'b1;
	end
	// one clock: pins set while low, serial_out read just before the rise
	task automatic tick(input logic d, input logic l, input logic b, output logic so);
		serial_in = d;
		latch_strobe_modesel_a = l;
		blank_n_modesel_b = b;
		#62.5;
		so = serial_out;
		serial_clk = 1'b1;
		#62.5;
		serial_clk = 1'b0;
	endtask
	// sixteen bits msb first, latch raised with the last one
	task automatic word(input logic [15:0] w, input logic lat, output logic [15:0] got);
		logic so;
		for (int i = 15; i >= 0; i--) begin
			tick(w[i], lat && i == 0, blank_n_modesel_b, so);
			got[i] = so;
		end
		latch_strobe_modesel_a = 1'b0;
		// a released data line shows the inverse, never a stale copy
		serial_in = ~serial_in;
	endtask
	// five-clock mode pattern, bit k sampled on clock k+1
	task automatic seq(input logic [4:0] b, input logic [4:0] l);
		logic so;
		for (int k = 0; k < 5; k++) begin
			tick(~serial_in, l[k], b[k], so);
		end
		latch_strobe_modesel_a = 1'b0;
	endtask
	// blank level, held low by the caller for the whole evaluation
	task automatic set_blank(input logic b);
		blank_n_modesel_b = b;
	endtask
endmodule

// file: tb/tb.sv
// self-checking bench for the led sink fault detection core
`timescale 1ns/10ps
module tb;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic sclk, sdat, lat, blk, sout, psave, fmode;
	logic [15:0] sink;
	lsf_pkg::lsf_sense_s sense = {16'hFFFF, 16'h0000, 16'hFFFF};
	int bad_count = 0;
	int check_count = 0;
	int cyc = 0;

	// system clock, 50 ns period
	always #25 sys_clk = ~sys_clk;

	lsf_top dut (.sys_clk(sys_clk), .nrst(nrst), .serial_clk(sclk), .serial_in(sdat),
		.latch_strobe_modesel_a(lat), .blank_n_modesel_b(blk), .serial_out(sout),
		.sensed_channel_current(sense), .sink_channel(sink), .power_save(psave),
		.fault_mode(fmode));
	lsf_host_model host (.serial_clk(sclk), .serial_in(sdat), .latch_strobe_modesel_a(lat),
		.blank_n_modesel_b(blk), .serial_out(sout));

	task end_of_test;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// hang guard, far above the roughly 600 cycles the run needs
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			end_of_test();
		end
	end

	task check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// settle time covers the sync into sys_clk plus the drive flop
	task wait_sys(input int n);
		repeat (n) @(posedge sys_clk);
		#5;
	endtask

	task t_reset;
		check({15'h0000, psave}, 16'h0001);
		check(sink, 16'h0000);
		check({15'h0000, fmode}, 16'h0000);
	endtask

	task t_normal;
		logic [15:0] got;
		host.word(16'hA5C3, 1'b1, got);
		wait_sys(10);
		check(sink, 16'h0000);
		check({15'h0000, psave}, 16'h0000);
		host.set_blank(1'b0);
		wait_sys(10);
		check(sink, 16'hA5C3);
		// new word shifted without a latch pulse must not reach the outputs
		host.word(16'h5A3C, 1'b0, got);
		check(got, 16'hA5C3);
		wait_sys(10);
		check(sink, 16'hA5C3);
		host.word(16'h0000, 1'b1, got);
		check(got, 16'h5A3C);
		wait_sys(10);
		check({15'h0000, psave}, 16'h0001);
		check(sink, 16'h0000);
		host.set_blank(1'b1);
	endtask

	task t_detect;
		logic [15:0] got;
		host.seq(lsf_pkg::SEQ_BLANK, lsf_pkg::ENTRY_LATCH);
		wait_sys(10);
		check({15'h0000, fmode}, 16'h0001);
		host.word(16'hFFFF, 1'b1, got);
		@(posedge sys_clk);
		#5;
		sense = {16'hF0FF, 16'h0081, 16'hFF7E};
		host.set_blank(1'b0);
		wait_sys(6);
		check(sink, 16'hFFFF);
		wait_sys(30);
		host.set_blank(1'b1);
		wait_sys(10);
		// the result load takes the third clock after the handoff settles
		repeat (3) host.tick(1'b0, 1'b0, 1'b1, got[0]);
		host.word(16'h0000, 1'b0, got);
		check(got, 16'hF07E);
	endtask

	task t_exit;
		logic [15:0] got;
		host.seq(lsf_pkg::SEQ_BLANK, lsf_pkg::ENTRY_LATCH);
		wait_sys(10);
		check({15'h0000, fmode}, 16'h0001);
		// pattern broken at the fourth clock, then a clean exit right after
		host.seq(5'h05, 5'h00);
		wait_sys(10);
		check({15'h0000, fmode}, 16'h0001);
		host.seq(lsf_pkg::SEQ_BLANK, lsf_pkg::EXIT_LATCH);
		wait_sys(10);
		check({15'h0000, fmode}, 16'h0000);
		host.seq(lsf_pkg::SEQ_BLANK, lsf_pkg::ENTRY_LATCH);
		wait_sys(10);
		check({15'h0000, fmode}, 16'h0001);
		// second check after the round trip: bit 0 clears at the low threshold, bit 7 holds
		host.word(16'hFFFF, 1'b1, got);
		@(posedge sys_clk);
		#5;
		sense = {16'hFFFF, 16'h0000, 16'h0001};
		host.set_blank(1'b0);
		wait_sys(36);
		host.set_blank(1'b1);
		wait_sys(10);
		repeat (3) host.tick(1'b0, 1'b0, 1'b1, got[0]);
		host.word(16'h0000, 1'b0, got);
		check(got, 16'hFF7F);
		host.seq(lsf_pkg::SEQ_BLANK, lsf_pkg::EXIT_LATCH);
		wait_sys(10);
		check({15'h0000, fmode}, 16'h0000);
	endtask

	// main sequence: reset, two dummy clocks for the link reset, scenarios
	initial begin
		logic so;
		repeat (3) @(posedge sys_clk);
		#5;
		nrst = 1'b1;
		wait_sys(2);
		host.tick(1'b0, 1'b0, 1'b1, so);
		host.tick(1'b1, 1'b0, 1'b1, so);
		t_reset();
		t_normal();
		t_detect();
		t_exit();
		end_of_test();
	end
endmodule
